// ==== hdl/spu_irq_gate.sv ====
`timescale 1ns/1ps
`default_nettype none
// global enable with one instruction of delay before interrupts
module spu_irq_gate (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic set_gie,
	input wire logic clr_gie,
	input wire logic instr_done,
	input wire logic entry_start,
	input wire logic iret_done,
	output logic gie,
	output logic armed
);
	// global enable flag; entry clears it, return sets it
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			gie <= 1'b0;
		end else if (set_gie || iret_done) begin
			gie <= 1'b1;
		end else if (clr_gie || entry_start) begin
			gie <= 1'b0;
		end
	end

	// arm only after the instruction following the enable retires
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			armed <= 1'b0;
		end else if (set_gie || clr_gie || entry_start) begin
			armed <= 1'b0;
		end else if (gie && instr_done) begin
			armed <= 1'b1;
		end
	end
endmodule // spu_irq_gate
`default_nettype wire

// ==== hdl/spu_pkg.sv ====
package spu_pkg;

	// data space width and top of data memory
	localparam int SPU_ADDR_W = 16;
	localparam logic [15:0] SPU_TOP_OF_DATA_MEMORY = 16'h04ff;
	localparam logic [15:0] SPU_STACK_FLOOR = 16'h0100;

	// register indices on the plain register port
	localparam logic [3:0] SPU_REG_SP_LOW = 4'h0;
	localparam logic [3:0] SPU_REG_SP_HIGH = 4'h1;
	localparam logic [3:0] SPU_REG_X_LOW = 4'h2;
	localparam logic [3:0] SPU_REG_X_HIGH = 4'h3;
	localparam logic [3:0] SPU_REG_Y_LOW = 4'h4;
	localparam logic [3:0] SPU_REG_Y_HIGH = 4'h5;
	localparam logic [3:0] SPU_REG_Z_LOW = 4'h6;
	localparam logic [3:0] SPU_REG_Z_HIGH = 4'h7;
	localparam logic [3:0] SPU_REG_STATUS = 4'h8;

	// status register bit positions
	localparam int SPU_ST_GIE = 0;
	localparam int SPU_ST_ENTRY = 1;
	localparam int SPU_ST_LOW_SP = 2;

	// interrupt entry lasts this many cycles at least
	localparam int SPU_ENTRY_CYCLES = 4;
	localparam logic [2:0] SPU_ENTRY_LAST = 3'h3;

	// stack operations requested by the core
	typedef enum logic [2:0] {
		SPU_OP_NONE,
		SPU_OP_PUSH,
		SPU_OP_POP,
		SPU_OP_CALL,
		SPU_OP_RET,
		SPU_OP_IRET
	} spu_stack_op_t;

	// pointer addressing modes
	typedef enum logic [1:0] {
		SPU_AM_PLAIN,
		SPU_AM_DISP,
		SPU_AM_POSTINC,
		SPU_AM_PREDEC
	} spu_addr_mode_t;

	// pointer request from the core
	typedef struct packed {
		logic valid;
		logic [1:0] sel;
		spu_addr_mode_t mode;
		logic [5:0] disp;
	} spu_ptr_req_t;

	// register port request
	typedef struct packed {
		logic wr;
		logic rd;
		logic [3:0] addr;
		logic [7:0] wdata;
	} spu_reg_req_t;

endpackage

// ==== hdl/spu_ptr_calc.sv ====
`timescale 1ns/1ps
`default_nettype none
// address generation for one pointer pair access
module spu_ptr_calc
	import spu_pkg::*;
#(
	parameter int W = SPU_ADDR_W
) (
	input wire logic [W-1:0] ptr,
	input wire spu_addr_mode_t mode,
	input wire logic [5:0] disp,
	output logic [W-1:0] eff_addr,
	output logic [W-1:0] next_ptr
);
	// effective address and written-back pointer
	always_comb begin
		eff_addr = ptr;
		next_ptr = ptr;
		unique case (mode)
			SPU_AM_PLAIN: begin
				eff_addr = ptr;
			end
			SPU_AM_DISP: begin
				eff_addr = ptr + W'(disp);
			end
			SPU_AM_POSTINC: begin
				next_ptr = ptr + W'(1);
			end
			SPU_AM_PREDEC: begin
				next_ptr = ptr - W'(1);
				eff_addr = ptr - W'(1);
			end
		endcase
	end
endmodule // spu_ptr_calc
`default_nettype wire

// ==== hdl/spu_stack_pointer_unit.sv ====
// Local design decisions: the register addresses and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module spu_stack_pointer_unit
	import spu_pkg::*;
#(
	parameter int SP_BITS = 16, // implemented pointer bits
	parameter logic [15:0] TOP = SPU_TOP_OF_DATA_MEMORY
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire spu_reg_req_t reg_req,
	output logic [7:0] reg_rdata,
	input wire spu_stack_op_t stack_op,
	input wire spu_ptr_req_t ptr_req,
	input wire logic [7:0] gpr_wdata,
	input wire logic [2:0] gpr_wsel,
	input wire logic gpr_we,
	input wire logic set_gie,
	input wire logic clr_gie,
	input wire logic instr_done,
	input wire logic irq_pending,
	input wire logic interrupt_exit,
	output logic [15:0] stack_pointer,
	output logic [15:0] stack_addr,
	output logic [15:0] ptr_addr,
	output logic ptr_addr_valid,
	output logic irq_take,
	output logic entry_busy,
	output logic gie
);
	////////////////////////////////////////////////////////////////
	// storage
	logic [SP_BITS-1:0] sp; // implemented pointer bits only
	logic [7:0] ptr_reg [6]; // pointer pair bytes, low then high
	logic [2:0] entry_cnt; // cycles spent in interrupt entry
	logic armed; // interrupt may be taken
	logic gie_q; // enable from gate
	logic entry_start; // first cycle of entry
	logic entry_end; // last entry cycle
	logic [15:0] sel_ptr; // chosen pointer pair
	logic [15:0] calc_addr; // address from the calculator
	logic [15:0] calc_next; // written-back pointer value
	logic [15:0] sp_full; // pointer zero-extended
	logic [SP_BITS-1:0] next_sp; // pointer after this cycle

	typedef enum logic {SPU_IDLE, SPU_ENTRY} spu_state_t;
	spu_state_t state;

	// widen the pointer; absent upper bits read as zero
	function automatic logic [15:0] spu_widen(input logic [SP_BITS-1:0] v);
		spu_widen = 16'(v);
	endfunction

	assign sp_full = spu_widen(sp);

	////////////////////////////////////////////////////////////////
	// pointer pairs
	// pick the pair the core addresses
	always_comb begin
		unique case (ptr_req.sel)
			2'h0: sel_ptr = {ptr_reg[1], ptr_reg[0]};
			2'h1: sel_ptr = {ptr_reg[3], ptr_reg[2]};
			default: sel_ptr = {ptr_reg[5], ptr_reg[4]};
		endcase
	end

	spu_ptr_calc #(
		.W(16)
	) u_calc (
		.ptr(sel_ptr),
		.mode(ptr_req.mode),
		.disp(ptr_req.disp),
		.eff_addr(calc_addr),
		.next_ptr(calc_next)
	);

	// pair bytes: core write, auto update, then software write
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			for (int i = 0; i < 6; i++) begin
				ptr_reg[i] <= 8'h00;
			end
		end else begin
			if (gpr_we && gpr_wsel < 3'h6) begin
				ptr_reg[gpr_wsel] <= gpr_wdata;
			end
			// auto update wins over a core write of the same pair
			if (ptr_req.valid && ptr_req.sel != 2'h3 &&
			    (ptr_req.mode == SPU_AM_POSTINC || ptr_req.mode == SPU_AM_PREDEC)) begin
				ptr_reg[{ptr_req.sel, 1'b0}] <= calc_next[7:0];
				ptr_reg[{ptr_req.sel, 1'b1}] <= calc_next[15:8];
			end
			if (reg_req.wr && reg_req.addr >= SPU_REG_X_LOW &&
			    reg_req.addr <= SPU_REG_Z_HIGH) begin
				ptr_reg[3'(reg_req.addr - SPU_REG_X_LOW)] <= reg_req.wdata;
			end
		end
	end

	// address out to the data space
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			ptr_addr <= 16'h0000;
			ptr_addr_valid <= 1'b0;
		end else begin
			ptr_addr <= calc_addr;
			ptr_addr_valid <= ptr_req.valid && ptr_req.sel != 2'h3;
		end
	end

	////////////////////////////////////////////////////////////////
	// stack pointer
	// movement for each stack operation; entry saves two bytes
	always_comb begin
		next_sp = sp;
		if (entry_start) begin
			next_sp = sp - SP_BITS'(2);
		end else begin
			unique case (stack_op)
				SPU_OP_NONE: next_sp = sp;
				SPU_OP_PUSH: next_sp = sp - SP_BITS'(1);
				SPU_OP_POP: next_sp = sp + SP_BITS'(1);
				SPU_OP_CALL: next_sp = sp - SP_BITS'(2);
				SPU_OP_RET: next_sp = sp + SP_BITS'(2);
				SPU_OP_IRET: next_sp = sp + SP_BITS'(2);
				default: next_sp = sp;
			endcase
		end
		// software bytes replace the pointer for the next operation
		if (reg_req.wr && reg_req.addr == SPU_REG_SP_LOW) begin
			next_sp[7:0] = reg_req.wdata;
		end
		if (reg_req.wr && reg_req.addr == SPU_REG_SP_HIGH && SP_BITS > 8) begin
			next_sp = SP_BITS'({reg_req.wdata, sp_full[7:0]});
		end
	end

	// stack pointer register, starting at the top of memory
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			sp <= SP_BITS'(TOP);
		end else begin
			sp <= next_sp;
		end
	end

	// address used by push or entry: pointer is the top, store then move
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			stack_pointer <= TOP;
			stack_addr <= TOP;
		end else begin
			stack_pointer <= spu_widen(next_sp);
			stack_addr <= (stack_op == SPU_OP_POP || stack_op == SPU_OP_RET ||
				stack_op == SPU_OP_IRET) ? sp_full + 16'h0001 : sp_full;
		end
	end

	////////////////////////////////////////////////////////////////
	// interrupts
	spu_irq_gate u_gate (
		.sys_clk(sys_clk),
		.rst(rst),
		.set_gie(set_gie),
		.clr_gie(clr_gie),
		.instr_done(instr_done),
		.entry_start(entry_start),
		.iret_done(interrupt_exit),
		.gie(gie_q),
		.armed(armed)
	);

	assign entry_start = (state == SPU_IDLE) && armed && irq_pending && instr_done;
	assign entry_end = (state == SPU_ENTRY) && (entry_cnt == SPU_ENTRY_LAST);

	// entry sequence: program counter is saved during the four cycles
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			state <= SPU_IDLE;
			entry_cnt <= 3'h0;
		end else begin
			unique case (state)
				SPU_IDLE: begin
					entry_cnt <= 3'h0;
					if (entry_start) begin
						state <= SPU_ENTRY;
					end
				end
				SPU_ENTRY: begin
					entry_cnt <= entry_cnt + 3'h1;
					if (entry_end) begin
						state <= SPU_IDLE;
					end
				end
			endcase
		end
	end

	// core-facing interrupt flags
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			irq_take <= 1'b0;
			entry_busy <= 1'b0;
			gie <= 1'b0;
		end else begin
			irq_take <= entry_start;
			entry_busy <= entry_start || (state == SPU_ENTRY && !entry_end);
			gie <= gie_q;
		end
	end

	////////////////////////////////////////////////////////////////
	// register read port, data one cycle after the strobe
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			reg_rdata <= 8'h00;
		end else if (reg_req.rd) begin
			unique case (reg_req.addr)
				SPU_REG_SP_LOW: reg_rdata <= sp_full[7:0];
				SPU_REG_SP_HIGH: reg_rdata <= sp_full[15:8];
				SPU_REG_X_LOW, SPU_REG_X_HIGH, SPU_REG_Y_LOW, SPU_REG_Y_HIGH,
				SPU_REG_Z_LOW, SPU_REG_Z_HIGH:
					reg_rdata <= ptr_reg[3'(reg_req.addr - SPU_REG_X_LOW)];
				SPU_REG_STATUS: begin
					reg_rdata <= 8'h00;
					reg_rdata[SPU_ST_GIE] <= gie_q;
					reg_rdata[SPU_ST_ENTRY] <= (state == SPU_ENTRY);
					// flags a pointer at or below the floor software must avoid
					reg_rdata[SPU_ST_LOW_SP] <= (sp_full <= SPU_STACK_FLOOR);
				end
				default: reg_rdata <= 8'h00; // unmapped reads zero
			endcase
		end else begin
			reg_rdata <= 8'h00;
		end
	end
endmodule // spu_stack_pointer_unit
`default_nettype wire

// ==== tb/spu_core_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// core model: retires an issued instruction after one or three cycles
module spu_core_model (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic issue,
	input wire logic slow,
	output logic instr_done
);
	logic [1:0] cnt; // cycles left before retirement
	// slow mode mimics a multi-cycle instruction
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			cnt <= 2'h0;
			instr_done <= 1'b0;
		end else begin
			instr_done <= (cnt == 2'h1);
			if (issue) begin
				cnt <= slow ? 2'h3 : 2'h1;
			end else if (cnt != 2'h0) begin
				cnt <= cnt - 2'h1;
			end
		end
	end
endmodule // spu_core_model
`default_nettype wire

// ==== tb/spu_sp_assertions.sv ====
`timescale 1ns/1ps
`default_nettype none
// pointer moves, entry timing and register reads seen at the ports
module spu_sp_assertions
	import spu_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rst,
	input wire spu_reg_req_t reg_req,
	input wire logic [7:0] reg_rdata,
	input wire spu_stack_op_t stack_op,
	input wire logic instr_done,
	input wire logic irq_pending,
	input wire logic set_gie,
	input wire logic [15:0] stack_pointer,
	input wire logic [15:0] stack_addr,
	input wire logic irq_take,
	input wire logic entry_busy,
	input wire logic gie
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	logic q; // no write and no entry that could override the op
	assign q = !reg_req.wr && !irq_pending;
	////////////////////////////////////////////////////////////////
	AST_PUSH: assert property (stack_op == SPU_OP_PUSH && q |=>
		stack_pointer == $past(stack_pointer) - 16'h1) else $error("push move");
	AST_POP: assert property (stack_op == SPU_OP_POP && q |=>
		stack_pointer == $past(stack_pointer) + 16'h1) else $error("pop move");
	AST_CALL: assert property (stack_op == SPU_OP_CALL && q |=>
		stack_pointer == $past(stack_pointer) - 16'h2) else $error("call move");
	AST_RET: assert property ((stack_op inside {SPU_OP_RET, SPU_OP_IRET}) && q |=>
		stack_pointer == $past(stack_pointer) + 16'h2) else $error("return move");
	AST_IDLE: assert property (stack_op == SPU_OP_NONE && q |=>
		$stable(stack_pointer)) else $error("pointer drifted");
	// the enable output is registered once more, so it drops a cycle after the take
	AST_ENTRY: assert property (irq_take && !$past(reg_req.wr) |->
		stack_pointer == $past(stack_pointer) - 16'h2 ##1 !gie) else $error("entry");
	// a take needs a retiring instruction and an enable at least three edges old
	AST_SEI: assert property (irq_take |->
		$past(instr_done) && !$past(set_gie) && !$past(set_gie, 2)) else $error("taken too early");
	AST_ADDR_DN: assert property ((stack_op inside {SPU_OP_PUSH, SPU_OP_CALL}) && q |=>
		stack_addr == $past(stack_pointer)) else $error("store address");
	AST_ADDR_UP: assert property ((stack_op inside {SPU_OP_POP, SPU_OP_RET, SPU_OP_IRET}) && q |=>
		stack_addr == $past(stack_pointer) + 16'h1) else $error("load address");
	AST_BUSY: assert property ($rose(entry_busy) |-> irq_take ##0 entry_busy[*4])
		else $error("entry too short");
	AST_SP_WR: assert property (reg_req.wr && reg_req.addr == SPU_REG_SP_LOW |=>
		stack_pointer[7:0] == $past(reg_req.wdata)) else $error("low write");
	AST_SP_RD: assert property (reg_req.rd && reg_req.addr == SPU_REG_SP_HIGH |=>
		reg_rdata == $past(stack_pointer[15:8])) else $error("high read");
endmodule // spu_sp_assertions
bind spu_stack_pointer_unit spu_sp_assertions chk (.sys_clk, .rst, .reg_req, .reg_rdata,
	.stack_op, .instr_done, .irq_pending, .set_gie, .stack_pointer, .stack_addr, .irq_take,
	.entry_busy, .gie);
`default_nettype wire

// ==== tb/testbench.sv ====
`timescale 1ns/1ps
`default_nettype none
// self-checking bench: register port, stack ops, pointers, entry
module testbench;
	import spu_pkg::*;
	logic sys_clk, rst, gpr_we, set_gie, clr_gie, instr_done, irq_pending, interrupt_exit;
	logic ptr_addr_valid, entry_busy, issue, slw;
	logic rd_d = 1'b0; // a read answer stands this cycle
	spu_reg_req_t reg_req;
	spu_stack_op_t stack_op;
	spu_ptr_req_t ptr_req;
	logic [7:0] reg_rdata, gpr_wdata, hi, lo;
	logic [2:0] gpr_wsel;
	logic [15:0] ptr_addr, sp;
	logic [15:0] p [3]; // pointer model
	logic [15:0] qr[$]; // {mask, expected} per read
	logic [15:0] qp[$]; // expected pointer addresses
	int n_mismatch, n_compared, cyc, seed, i;
	spu_stack_op_t ops [5] = '{SPU_OP_PUSH, SPU_OP_POP, SPU_OP_CALL, SPU_OP_RET, SPU_OP_IRET};
	spu_stack_pointer_unit uut (.sys_clk, .rst, .reg_req, .reg_rdata, .stack_op, .ptr_req,
		.gpr_wdata, .gpr_wsel, .gpr_we, .set_gie, .clr_gie, .instr_done, .irq_pending,
		.interrupt_exit, .stack_pointer(), .stack_addr(), .ptr_addr, .ptr_addr_valid,
		.irq_take(), .entry_busy, .gie());
	spu_core_model core (.sys_clk, .rst, .issue, .slow(slw), .instr_done);
	////////////////////////////////////////////////////////////////
	task results;
		$display("compared %0d mismatches %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	task chk_rd(input logic [7:0] got);
		logic [15:0] e;
		e = qr.pop_front();
		n_compared++;
		if ((got & e[15:8]) !== e[7:0]) begin
			n_mismatch++;
			$display("wrong value %0t read %h want %h", $time, got, e[7:0]);
		end
	endtask
	task chk_ptr(input logic [15:0] got);
		logic [15:0] e;
		e = qp.pop_front();
		n_compared++;
		if (got !== e) begin
			n_mismatch++;
			$display("wrong value %0t address %h want %h", $time, got, e);
		end
	endtask
	task wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		reg_req <= '{1'b1, 1'b0, a, d};
		@(posedge sys_clk);
		reg_req <= '0;
	endtask
	task rd(input logic [3:0] a, input logic [7:0] v, input logic [7:0] m);
		qr.push_back({m, v & m});
		@(posedge sys_clk);
		reg_req <= '{1'b0, 1'b1, a, 8'h00};
		@(posedge sys_clk);
		reg_req <= '0;
	endtask
	task chk_sp;
		rd(SPU_REG_SP_LOW, sp[7:0], 8'hff);
		rd(SPU_REG_SP_HIGH, sp[15:8], 8'hff);
	endtask
	// stack op held until the next call changes it
	task op(input spu_stack_op_t o);
		@(posedge sys_clk);
		stack_op <= o;
		case (o)
			SPU_OP_PUSH: sp = sp - 16'h1;
			SPU_OP_POP: sp = sp + 16'h1;
			SPU_OP_CALL: sp = sp - 16'h2;
			SPU_OP_NONE: ;
			default: sp = sp + 16'h2;
		endcase
	endtask
	task pr(input logic [1:0] s, input spu_addr_mode_t m, input logic [5:0] d);
		logic [15:0] a;
		a = p[s];
		case (m)
			SPU_AM_DISP: a = p[s] + {10'h000, d};
			SPU_AM_POSTINC: p[s] = p[s] + 16'h1;
			SPU_AM_PREDEC: begin
				p[s] = p[s] - 16'h1;
				a = p[s];
			end
			default: ;
		endcase
		qp.push_back(a);
		@(posedge sys_clk);
		ptr_req <= '{1'b1, s, m, d};
		@(posedge sys_clk);
		ptr_req <= '0;
	endtask
	// issue one instruction to the core model, wait for it to retire
	task run(input logic s);
		@(posedge sys_clk);
		issue <= 1'b1;
		slw <= s;
		@(posedge sys_clk);
		issue <= 1'b0;
		for (i = 0; i < 8 && instr_done !== 1'b1; i++) @(posedge sys_clk);
		if (instr_done !== 1'b1) begin
			n_mismatch++;
			$display("wrong value %0t instruction never retired", $time);
		end
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		sys_clk = 1'b0;
		forever #20 sys_clk = ~sys_clk;
	end
	// result watcher; also cuts a hang short
	always @(posedge sys_clk) begin
		if (rd_d) chk_rd(reg_rdata);
		if (ptr_addr_valid === 1'b1) chk_ptr(ptr_addr);
		rd_d <= reg_req.rd;
		cyc++;
		if (cyc == 3000) begin
			n_mismatch++;
			results;
		end
	end
	initial begin
		seed = 57631;
		{rst, gpr_we, set_gie, clr_gie, irq_pending, interrupt_exit, issue, slw} = 8'h80;
		reg_req = '0;
		stack_op = SPU_OP_NONE;
		ptr_req = '0;
		gpr_wdata = 8'h00;
		gpr_wsel = 3'h0;
		repeat (6) @(posedge sys_clk);
		rst <= 1'b0;
		sp = SPU_TOP_OF_DATA_MEMORY;
		chk_sp;
		rd(4'h9, 8'h00, 8'hff); // unmapped reads zero
		foreach (ops[k]) begin
			op(ops[k]);
			op(ops[k]);
			op(SPU_OP_NONE);
			chk_sp;
		end
		hi = 8'h02 + 8'($random(seed) & 3);
		lo = 8'($random(seed));
		wr(SPU_REG_SP_LOW, lo);
		wr(SPU_REG_SP_HIGH, hi);
		sp = {hi, lo};
		op(SPU_OP_NONE);
		rd(SPU_REG_SP_HIGH, hi, 8'hff);
		chk_sp;
		for (int s = 0; s < 3; s++) begin
			p[s] = 16'($random(seed));
			wr(4'(2 * s + 2), p[s][7:0]);
			wr(4'(2 * s + 3), p[s][15:8]);
		end
		@(posedge sys_clk);
		gpr_we <= 1'b1;
		gpr_wsel <= 3'h2;
		gpr_wdata <= 8'h5a;
		p[1][7:0] = 8'h5a;
		@(posedge sys_clk);
		gpr_we <= 1'b0;
		for (int s = 0; s < 3; s++) begin
			for (int m = 0; m < 4; m++) pr(2'(s), spu_addr_mode_t'(m), 6'($random(seed)));
			rd(4'(2 * s + 2), p[s][7:0], 8'hff);
			rd(4'(2 * s + 3), p[s][15:8], 8'hff);
		end
		@(posedge sys_clk);
		set_gie <= 1'b1;
		@(posedge sys_clk);
		set_gie <= 1'b0;
		irq_pending <= 1'b1;
		run(1'b0);
		chk_sp;
		run(1'b1);
		irq_pending <= 1'b0;
		repeat (2) @(posedge sys_clk);
		for (i = 0; i < 20 && entry_busy === 1'b1; i++) @(posedge sys_clk);
		if (entry_busy !== 1'b0) begin
			n_mismatch++;
			$display("wrong value %0t entry never ended", $time);
		end
		sp = sp - 16'h2;
		chk_sp;
		rd(SPU_REG_STATUS, 8'h00, 8'h07);
		op(SPU_OP_IRET);
		interrupt_exit <= 1'b1;
		op(SPU_OP_NONE);
		interrupt_exit <= 1'b0;
		chk_sp;
		rd(SPU_REG_STATUS, 8'h01, 8'h07);
		@(posedge sys_clk);
		clr_gie <= 1'b1;
		@(posedge sys_clk);
		clr_gie <= 1'b0;
		rd(SPU_REG_STATUS, 8'h00, 8'h07);
		// pointer left at the floor: the low-stack flag must show it
		wr(SPU_REG_SP_HIGH, 8'h01);
		wr(SPU_REG_SP_LOW, 8'h00);
		sp = 16'h0100;
		rd(SPU_REG_STATUS, 8'h04, 8'h04);
		chk_sp;
		// reset in mid-run brings the pointer back to the top
		@(posedge sys_clk);
		rst <= 1'b1;
		repeat (2) @(posedge sys_clk);
		rst <= 1'b0;
		sp = SPU_TOP_OF_DATA_MEMORY;
		chk_sp;
		rd(SPU_REG_X_LOW, 8'h00, 8'hff);
		repeat (3) @(posedge sys_clk);
		results;
	end
endmodule // testbench
`default_nettype wire
